// ---- hw/tela_pkg.sv ----
// Package: constants, register map and carrier types of the terminal error latch block
//
// Contract
// R1: Transmit parity trigger toggles per one bit.
// R2: Bad receive character sets receive and line latches.
// R3: Line parity latch holds until parity reset.
// R4: Buffer fault on odd latch off at time six.
// R5: Buffer fault sets general and electronic latches.
// R6: No buffered option, electronic latch never sets.
// R7: Seven-bit check and enable loaded at print.
// R8: Checking enabled only in listed modes.
// R9: Returned feedback clears enabled check latch.
// R10: Extra feedback bit sets its check latch.
// R11: Two-stage sequence on phase one and two.
// R12: Error sample gates printer error and lock.
// R13: Case or overflow sets general and inhibit.
// R14: Stage two without one clears check registers.
// R15: Reentry lock cleared only by reset key.
// R16: Transmit parity latch sets at character end.
// R17: Answerback ranks electronic, printer, receive, transmit.
// R18: Error character first, acknowledge delayed second.
// R19: Qualified positive with status, negative without.
// R20: Negative keeps latches; status clears after first.
// R21: Reset clears latches, registers and sequence.
package tela_pkg;

   // APB register byte offsets
   localparam logic [3:0] TELA_OFF_CTRL = 4'h0;
   localparam logic [3:0] TELA_OFF_CMD  = 4'h4;
   localparam logic [3:0] TELA_OFF_STAT = 4'h8;
   localparam logic [3:0] TELA_OFF_ANSW = 4'hc;

   // Field positions
   localparam int unsigned TELA_CTRL_BUFOPT = 0;  // Buffered receive option installed
   localparam int unsigned TELA_CMD_PRST    = 0;  // Parity reset switch, write one
   localparam int unsigned TELA_CMD_RKEY    = 1;  // Reset key, write one
   localparam int unsigned TELA_ANSW_HOLD   = 4;  // Acknowledge held back

   // Reset values
   localparam logic       TELA_CTRL_RST = 1'b0;

   // Answerback error character codes
   localparam logic [2:0] TELA_ERR_NONE = 3'h0;
   localparam logic [2:0] TELA_ERR_ELEC = 3'h1;
   localparam logic [2:0] TELA_ERR_PRT  = 3'h2;
   localparam logic [2:0] TELA_ERR_RXP  = 3'h3;
   localparam logic [2:0] TELA_ERR_TXP  = 3'h4;

   // Terminal mode levels
   typedef struct packed {
      logic transmit;
      logic receive_text;
      logic alt_receive;
      logic rx_text_buffer;
      logic buffer_print;
      logic communicate;
      logic has_status;
      logic buffer_busy;
   } tela_mode_s;

   // Stored error latches, bit 0 is the line parity latch
   typedef struct packed {
      logic inhibit;
      logic rekey;
      logic general;
      logic printer;
      logic electronic;
      logic tx_par;
      logic rx_par;
      logic line_par;
   } tela_err_s;

   // Answerback sequence
   typedef enum logic [0:0] {
      TELA_AB_IDLE,
      TELA_AB_FIRST
   } tela_ab_e;

endpackage : tela_pkg

// ---- hw/tela_prchk.sv ----
// Printer feedback check registers and two-stage check sequence
`timescale 1ns/10ps
`default_nettype none

module tela_prchk
   import tela_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Cycle phases
   input  wire logic       cycle_phase_one_i,
   input  wire logic       cycle_phase_two_i,
   // Print time load
   input  wire logic       load_i,
   input  wire logic [6:0] print_holding_register_i,
   // Feedback
   input  wire logic       strobe_i,
   input  wire logic       feedback_window_close_pulse_i,
   input  wire logic [6:0] feedback_i,
   input  wire logic       check_en_i,
   // Results
   output logic            sample_o,
   output logic            error_sample_o,
   output logic            any_check_o,
   output logic            clear_regs_o
);

   logic [6:0] check_q;      // Check latches
   logic [6:0] enable_q;     // Check enable latches
   logic       sample_q;     // Feedback sample latch
   logic       stage1_q;     // Sequence stage one
   logic       stage2_q;     // Sequence stage two

   // End of check operation
   assign clear_regs_o   = stage2_q & ~stage1_q;  // R14
   assign error_sample_o = stage1_q & stage2_q;   // R12
   assign any_check_o    = |check_q;
   assign sample_o       = sample_q;

   // One check and enable pair per printed bit
   for (genvar b = 0; b < 7; b++) begin : g_bit
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            check_q[b]  <= 1'b0;  // R21
            enable_q[b] <= 1'b0;
         end else if (load_i) begin
            // Loaded before the holding register clears
            check_q[b]  <= print_holding_register_i[b];  // R7
            enable_q[b] <= print_holding_register_i[b];  // R7
         end else if (clear_regs_o) begin
            check_q[b]  <= 1'b0;  // R14
            enable_q[b] <= 1'b0;  // R14
         end else if (sample_q && feedback_i[b]) begin
            // Proper bit clears, extra bit sets
            check_q[b]  <= ~enable_q[b];  // R9 R10
         end
      end
   end

   // Sample latch opens on strobe, closes on the window close pulse
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sample_q <= 1'b0;
      end else if (check_en_i && strobe_i) begin
         sample_q <= 1'b1;
      end else if (feedback_window_close_pulse_i) begin
         sample_q <= 1'b0;
      end
   end

   // Stage one: set by sample on phase one, drops at phase one after stage two
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         stage1_q <= 1'b0;  // R21
      end else if (cycle_phase_one_i) begin
         stage1_q <= stage2_q ? 1'b0 : (stage1_q | sample_q);  // R11
      end
   end

   // Stage two: sets once the sample is over, drops after stage one
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         stage2_q <= 1'b0;  // R21
      end else if (cycle_phase_two_i) begin
         stage2_q <= stage1_q & (stage2_q | ~sample_q);  // R11
      end
   end

endmodule // tela_prchk

`default_nettype wire

// ---- hw/tela_top.sv ----
// Error detection, error latches and answerback selection of the terminal
`timescale 1ns/10ps
`default_nettype none

module tela_top
   import tela_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // APB slave
   input  wire logic       psel,
   input  wire logic       penable,
   input  wire logic       pwrite,
   input  wire logic [3:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]     prdata,
   output logic            pready,
   output logic            pslverr,
   // Terminal mode
   input  wire tela_mode_s mode_i,
   // Serial transmit
   input  wire logic       third_serial_send_step_i,
   input  wire logic       shift_reg_empty_i,
   input  wire logic       shift_reg_full_i,
   input  wire logic       serial_data_out_i,
   input  wire logic       tx_char_end_i,
   // Serial receive
   input  wire logic       rx_char_done_i,
   input  wire logic       rx_parity_even_i,
   input  wire logic       rx_stop_bit_position_missing_i,
   // Buffer traffic
   input  wire logic       buf_addr_time6_i,
   input  wire logic       buf_vcc_gate_i,
   input  wire logic       buf_write_i,
   input  wire logic       buf_odd_parity_i,
   // Printer
   input  wire logic       cycle_phase_one_i,
   input  wire logic       cycle_phase_two_i,
   input  wire logic       print_load_i,
   input  wire logic [6:0] print_holding_register_i,
   input  wire logic       feedback_strobe_i,
   input  wire logic       feedback_window_close_pulse_i,
   input  wire logic [6:0] feedback_bits_i,
   input  wire logic       incorrect_case_i,
   input  wire logic       holding_overflow_reset_i,
   // Answerback
   input  wire logic       load_first_answerback_i,
   input  wire logic       first_status_char_i,
   // Outputs
   output tela_err_s       err_o,
   output logic            buffer_parity_fault_o,
   output logic            error_sample_o,
   output logic            parity_light_o,
   output logic [2:0]      outgoing_character_register_o,
   output logic            ack_hold_o,
   output logic            ack_qual_pos_o,
   output logic            ack_qual_neg_o
);


   // Register state

   tela_err_s  err_q;          // Stored error latches
   logic       tx_odd_q;       // Transmit odd-parity trigger
   logic       bufopt_q;       // Buffered receive option
   logic [31:0] rdata_q;       // Read data captured in setup phase
   logic       slverr_q;       // Unmapped address in setup phase
   logic [2:0] outchar_q;      // Outgoing character register
   logic       first_q;        // Previous first status character level
   tela_ab_e   ab_q;           // Answerback sequence state
   tela_ab_e   ab_d;


   // APB decode

   wire setup_w  = psel & ~penable;
   wire access_w = psel & penable;
   wire hit_ctrl = (paddr == TELA_OFF_CTRL);
   wire hit_cmd  = (paddr == TELA_OFF_CMD);
   wire hit_stat = (paddr == TELA_OFF_STAT);
   wire hit_answ = (paddr == TELA_OFF_ANSW);
   wire mapped_w = hit_ctrl | hit_cmd | hit_stat | hit_answ;
   wire wr_w     = access_w & pwrite & ~slverr_q;

   // Command pulses act only at the completing edge
   wire par_reset_w = wr_w & hit_cmd & pwdata[TELA_CMD_PRST];
   wire reset_key_w = wr_w & hit_cmd & pwdata[TELA_CMD_RKEY];

   // Zero wait states; answer in the access cycle
   assign pready  = 1'b1;
   assign pslverr = access_w & slverr_q;
   assign prdata  = rdata_q;

   // Read mux evaluated in setup so read data comes from a flop
   logic [31:0] rmux_w;
   always_comb begin
      rmux_w = 32'h0000_0000;
      if (hit_ctrl) begin
         rmux_w[TELA_CTRL_BUFOPT] = bufopt_q;
      end else if (hit_stat) begin
         rmux_w[7:0] = err_q;
      end else if (hit_answ) begin
         rmux_w[2:0] = outchar_q;
         rmux_w[TELA_ANSW_HOLD] = ack_hold_o;
      end
   end

   // Capture read data and decode error during setup
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_q  <= 32'h0000_0000;
         slverr_q <= 1'b0;
      end else if (setup_w) begin
         rdata_q  <= pwrite ? 32'h0000_0000 : rmux_w;
         slverr_q <= ~mapped_w;
      end
   end

   // Option register steers whether electronic errors are kept
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         bufopt_q <= TELA_CTRL_RST;
      end else if (wr_w && hit_ctrl) begin
         bufopt_q <= pwdata[TELA_CTRL_BUFOPT];
      end
   end


   // Transmit parity

   // One bit sent: flip the trigger
   wire tx_flip_w = mode_i.transmit & third_serial_send_step_i
                  & ~shift_reg_empty_i & serial_data_out_i;  // R1
   // Character over with even count
   wire tx_bad_w  = tx_char_end_i & ~tx_odd_q & ~shift_reg_full_i;  // R16

   // Trigger restarts after each character is judged
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         tx_odd_q <= 1'b0;
      end else if (tx_char_end_i) begin
         tx_odd_q <= 1'b0;
      end else if (tx_flip_w) begin
         tx_odd_q <= ~tx_odd_q;  // R1
      end
   end


   // Receive parity

   // Even parity or lost stop bit, not in alternate receive
   wire rx_bad_w = rx_char_done_i & mode_i.receive_text & ~mode_i.alt_receive
                 & (rx_parity_even_i | rx_stop_bit_position_missing_i);  // R2


   // Buffer parity

   wire buf_fault_w = ~buf_odd_parity_i & buf_addr_time6_i
                    & buf_vcc_gate_i & buf_write_i;  // R4
   wire bp_comm_w   = mode_i.buffer_print & mode_i.communicate;
   // Electronic latch only exists with the buffered option
   wire elec_set_w  = bufopt_q & buf_fault_w
                    & (mode_i.receive_text | bp_comm_w);  // R5 R6
   wire gen_buf_w   = buf_fault_w & mode_i.receive_text;  // R5

   assign buffer_parity_fault_o = buf_fault_w;


   // Printer check

   // Checking allowed in these modes only
   wire check_en_w = (mode_i.receive_text & ~mode_i.rx_text_buffer)
                   | bp_comm_w;  // R8
   wire case_ovf_w = incorrect_case_i | holding_overflow_reset_i;  // R13

   logic sample_w;
   logic err_sample_w;
   logic any_check_w;
   logic clear_regs_w;

   // Check registers and sequence live in a leaf
   tela_prchk u_prchk (
      .clk_i                         (clk_i),
      .rst_n_i                       (rst_n_i),
      .cycle_phase_one_i             (cycle_phase_one_i),
      .cycle_phase_two_i             (cycle_phase_two_i),
      .load_i                        (print_load_i),
      .print_holding_register_i      (print_holding_register_i),
      .strobe_i                      (feedback_strobe_i),
      .feedback_window_close_pulse_i (feedback_window_close_pulse_i),
      .feedback_i                    (feedback_bits_i),
      .check_en_i                    (check_en_w),
      .sample_o                      (sample_w),
      .error_sample_o                (err_sample_w),
      .any_check_o                   (any_check_w),
      .clear_regs_o                  (clear_regs_w)
   );

   // Printer error only when a check latch remains and nothing inhibits it
   wire prt_set_w = err_sample_w & any_check_w & check_en_w & ~err_q.inhibit;  // R12

   assign error_sample_o = err_sample_w;


   // Answerback

   wire any_err_w  = err_q.electronic | err_q.printer | err_q.rx_par | err_q.tx_par;
   wire report_w   = any_err_w | mode_i.buffer_busy;
   // Falling edge of the first status character
   wire first_fall_w = first_q & ~first_status_char_i;
   // Clear happens only for a terminal with status; negative keeps all
   wire ab_clear_w = first_fall_w & mode_i.has_status & (ab_q == TELA_AB_FIRST);  // R20

   assign ack_qual_pos_o = report_w & mode_i.has_status;   // R19
   assign ack_qual_neg_o = report_w & ~mode_i.has_status;  // R19

   // Highest stored error wins
   logic [2:0] prio_w;
   always_comb begin
      prio_w = TELA_ERR_NONE;
      if (err_q.electronic && bufopt_q) begin
         prio_w = TELA_ERR_ELEC;  // R17
      end else if (err_q.printer) begin
         prio_w = TELA_ERR_PRT;   // R17
      end else if (err_q.rx_par) begin
         prio_w = TELA_ERR_RXP;   // R17
      end else if (err_q.tx_par) begin
         prio_w = TELA_ERR_TXP;   // R17
      end
   end

   // Sequence: acknowledge held while the error character goes first
   always_comb begin
      ab_d = ab_q;
      case (ab_q)
         TELA_AB_IDLE: begin
            if (load_first_answerback_i && mode_i.has_status) begin
               ab_d = TELA_AB_FIRST;  // R18
            end
         end
         TELA_AB_FIRST: begin
            if (first_fall_w) begin
               ab_d = TELA_AB_IDLE;
            end
         end
         default: begin
            ab_d = TELA_AB_IDLE;
         end
      endcase
   end

   assign ack_hold_o = (ab_q == TELA_AB_FIRST);  // R18

   // State and edge history
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ab_q    <= TELA_AB_IDLE;
         first_q <= 1'b0;
      end else begin
         ab_q    <= ab_d;
         first_q <= first_status_char_i;
      end
   end

   // Outgoing register takes the ranked error on load
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         outchar_q <= TELA_ERR_NONE;
      end else if (load_first_answerback_i && mode_i.has_status) begin
         outchar_q <= prio_w;  // R18
      end
   end

   assign outgoing_character_register_o = outchar_q;


   // Error latches; every set wins over its clear

   tela_err_s err_d;
   always_comb begin
      err_d = err_q;
      // Answerback with status clears the receive, transmit, electronic, printer and general latches
      if (ab_clear_w) begin
         err_d.rx_par     = 1'b0;  // R20
         err_d.tx_par     = 1'b0;
         err_d.electronic = 1'b0;
         err_d.printer    = 1'b0;
         err_d.general    = 1'b0;
      end
      // Line parity latch drops only on the parity reset
      if (par_reset_w) begin
         err_d.line_par = 1'b0;  // R3
      end
      // Reentry lock drops only on the reset key
      if (reset_key_w) begin
         err_d.rekey = 1'b0;  // R15
      end
      // Inhibit lasts for the current check operation
      if (clear_regs_w) begin
         err_d.inhibit = 1'b0;
      end
      if (tx_bad_w) begin
         err_d.tx_par   = 1'b1;  // R16
         err_d.line_par = 1'b1;  // R16
      end
      if (rx_bad_w) begin
         err_d.rx_par   = 1'b1;  // R2
         err_d.line_par = 1'b1;  // R2
      end
      if (gen_buf_w || case_ovf_w) begin
         err_d.general = 1'b1;  // R5 R13
      end
      if (elec_set_w) begin
         err_d.electronic = 1'b1;  // R5
      end
      if (case_ovf_w && check_en_w) begin
         err_d.inhibit = 1'b1;  // R13
      end
      if (prt_set_w) begin
         err_d.printer = 1'b1;  // R12
         err_d.rekey   = 1'b1;  // R12 R15
      end
   end

   // Latch register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         err_q <= '0;  // R21
      end else begin
         err_q <= err_d;
      end
   end

   // The line parity latch only reports, on the light and in the status register
   assign parity_light_o = err_q.line_par;  // R3
   assign err_o          = err_q;

endmodule // tela_top

`default_nettype wire

// ---- sim/tela_assertions.sv ----
// Port-level checks of the terminal error latch block
`timescale 1ns/10ps
`default_nettype none
module tela_assertions
   import tela_pkg::*;
(
   // Clock, reset and APB
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [3:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   // Stimulus
   input wire tela_mode_s  mode_i,
   input wire logic        cycle_phase_two_i,
   input wire logic        incorrect_case_i,
   input wire logic        load_first_answerback_i,
   // Results
   input wire tela_err_s   err_o,
   input wire logic        buffer_parity_fault_o,
   input wire logic        error_sample_o,
   input wire logic        parity_light_o,
   input wire logic        ack_hold_o,
   input wire logic        ack_qual_pos_o,
   input wire logic        ack_qual_neg_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // Completed writes and a copy of the option bit
   wire  wr_w  = psel && penable && pready && pwrite;
   wire  cmd_w = wr_w && paddr == TELA_OFF_CMD;
   logic opt_q;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         opt_q <= 1'b0;
      end else if (wr_w && paddr == TELA_OFF_CTRL) begin
         opt_q <= pwdata[TELA_CTRL_BUFOPT];
      end
   end
   a_line_hold: assert property (
      err_o.line_par && !(cmd_w && pwdata[TELA_CMD_PRST]) |=> err_o.line_par)
      else $error("line parity dropped");
   a_light_follow: assert property (
      parity_light_o == err_o.line_par) else $error("parity light differs");
   a_rekey_hold: assert property (
      err_o.rekey && !(cmd_w && pwdata[TELA_CMD_RKEY]) |=> err_o.rekey)
      else $error("rekey lock dropped");
   a_elec_blocked: assert property (
      !opt_q && !err_o.electronic |=> !err_o.electronic) else $error("electronic set");
   a_elec_set: assert property (
      opt_q && buffer_parity_fault_o && mode_i.receive_text |=> err_o.electronic
      && err_o.general) else $error("buffer fault not stored");
   a_case_general: assert property (
      incorrect_case_i |=> err_o.general) else $error("case error not stored");
   a_qual_ack: assert property (
      mode_i.buffer_busy |-> ack_qual_pos_o == mode_i.has_status
      && ack_qual_neg_o == !mode_i.has_status) else $error("qualified ack wrong");
   a_ab_hold: assert property (
      load_first_answerback_i && mode_i.has_status |=> ack_hold_o)
      else $error("ack not held");
   a_stage_order: assert property (
      $rose(error_sample_o) |-> $past(cycle_phase_two_i)) else $error("sample off phase");
   a_prt_sampled: assert property (
      $rose(err_o.printer) |-> $past(error_sample_o) && err_o.rekey)
      else $error("printer error unsampled");
   // Main scenarios reached
   c_sample: cover property (error_sample_o);
   c_elec_ab: cover property (err_o.electronic && ack_hold_o);
   c_prt_lock: cover property (err_o.printer && err_o.rekey);
endmodule // tela_assertions
`default_nettype wire

// ---- sim/tela_line_model.sv ----
// Behavioural line adapter side: send qualifiers and received character status
`timescale 1ns/10ps
`default_nettype none
module tela_line_model (
   // Clock
   input  wire logic clk_i,
   // Send side
   output logic      step_o,
   output logic      empty_o,
   output logic      full_o,
   output logic      data_o,
   output logic      char_end_o,
   // Receive side
   output logic      rx_done_o,
   output logic      rx_even_o,
   output logic      rx_nostop_o
);
   // Idle: shift register empty, no strobes
   initial begin
      {step_o, empty_o, full_o, data_o, char_end_o, rx_done_o, rx_even_o, rx_nostop_o} = 8'h40;
   end
   // One character, low bit first; data shows the inverse between steps
   task automatic send(input logic [7:0] c);
      {full_o, empty_o} <= 2'b10;
      for (int i = 0; i < 8; i++) begin
         {step_o, data_o} <= {1'b1, c[i]};
         @(posedge clk_i);
         {step_o, data_o} <= {1'b0, ~c[i]};
         @(posedge clk_i);
      end
      {full_o, empty_o, char_end_o} <= 3'b011;
      @(posedge clk_i);
      char_end_o <= 1'b0;
      @(posedge clk_i);
   endtask
   // Status levels are only valid with the done pulse
   task automatic recv(input logic even, input logic nostop);
      {rx_done_o, rx_even_o, rx_nostop_o} <= {1'b1, even, nostop};
      @(posedge clk_i);
      {rx_done_o, rx_even_o, rx_nostop_o} <= {1'b0, ~even, ~nostop};
      @(posedge clk_i);
   endtask
endmodule // tela_line_model
`default_nettype wire

// ---- sim/tela_tb_top.sv ----
// Self-checking bench of the terminal error latch block
`timescale 1ns/10ps
`default_nettype none
module tela_tb_top
   import tela_pkg::*;
;
   logic        clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, perr, fsc;
   logic [3:0]  paddr, bufl;
   logic [31:0] pwdata, prdata, rdat;
   logic [7:0]  pls;  // Pulses: ph1 ph2 load strobe close case ovf answerback
   logic [6:0]  hold, fb;
   logic        step, empty, full, sdo, cend, rxd, rxe, rxn;
   logic        bpf, esmp, light, ackh, qpos, qneg;
   logic [2:0]  outc;
   tela_mode_s  mode;
   tela_err_s   err;
   int          n_fail, samples_checked;
   tela_top dut (.clk_i, .rst_n_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .mode_i(mode), .third_serial_send_step_i(step),
      .shift_reg_empty_i(empty), .shift_reg_full_i(full), .serial_data_out_i(sdo),
      .tx_char_end_i(cend), .rx_char_done_i(rxd), .rx_parity_even_i(rxe),
      .rx_stop_bit_position_missing_i(rxn), .buf_addr_time6_i(bufl[3]),
      .buf_vcc_gate_i(bufl[2]), .buf_write_i(bufl[1]), .buf_odd_parity_i(bufl[0]),
      .cycle_phase_one_i(pls[0]), .cycle_phase_two_i(pls[1]), .print_load_i(pls[2]),
      .print_holding_register_i(hold), .feedback_strobe_i(pls[3]),
      .feedback_window_close_pulse_i(pls[4]), .feedback_bits_i(fb),
      .incorrect_case_i(pls[5]), .holding_overflow_reset_i(pls[6]),
      .load_first_answerback_i(pls[7]), .first_status_char_i(fsc), .err_o(err),
      .buffer_parity_fault_o(bpf), .error_sample_o(esmp), .parity_light_o(light),
      .outgoing_character_register_o(outc), .ack_hold_o(ackh), .ack_qual_pos_o(qpos),
      .ack_qual_neg_o(qneg));
   tela_line_model line (.clk_i, .step_o(step), .empty_o(empty), .full_o(full),
      .data_o(sdo), .char_end_o(cend), .rx_done_o(rxd), .rx_even_o(rxe), .rx_nostop_o(rxn));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Setup, then access held until pready is seen high
   task automatic apb(input logic [3:0] a, input logic w, input logic [31:0] d);
      int n = 0;
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk_i);
      end
      if (n == 20) n_fail++;
      rdat = prdata;
      perr = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      chk($sformatf("reg %h", a), exp, rdat);
   endtask
   task automatic pulse(input int b);
      pls[b] <= 1'b1;
      @(posedge clk_i);
      pls[b] <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic bufx(input logic odd);
      bufl <= {3'h7, odd};
      @(posedge clk_i);
      chk("buffer fault", {31'h0, ~odd}, {31'h0, bpf});
      bufl <= 4'h0;
      @(posedge clk_i);
   endtask
   // Print one character; phase one comes while the sample window is open
   task automatic prt(input logic [6:0] h, input logic [6:0] f);
      hold <= h;
      pulse(2);
      fb <= f;
      pulse(3);
      pulse(0);
      pulse(4);
      fb <= 7'h00;
      pulse(1);
      pulse(0);
      pulse(1);
   endtask
   task automatic ab(input logic [2:0] code, input logic hld);
      pulse(7);
      if (hld) chk("outgoing char", {29'h0, code}, {29'h0, outc});
      chk("ack hold", {31'h0, hld}, {31'h0, ackh});
      fsc <= 1'b1;
      @(posedge clk_i);
      fsc <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Watchdog; the run needs under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk_i);
      n_fail++;
      wrap_up();
   end
   initial begin
      {rst_n_i, psel, penable, pwrite, fsc, paddr, pwdata} = 41'h0;
      {mode, pls, bufl, hold, fb, n_fail, samples_checked} = 98'h0;
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      rd(TELA_OFF_CTRL, 32'h0);
      rd(TELA_OFF_STAT, 32'h0);
      apb(4'h1, 1'b0, 32'h0);
      chk("unmapped", 32'h1, {31'h0, perr});
      $display("test reset done");
      mode <= 8'h40;
      line.recv(1'b1, 1'b0);
      rd(TELA_OFF_STAT, 32'h3);
      apb(TELA_OFF_CMD, 1'b1, 32'h1);
      rd(TELA_OFF_STAT, 32'h2);
      mode <= 8'h60;
      line.recv(1'b0, 1'b1);
      rd(TELA_OFF_STAT, 32'h2);
      mode <= 8'h42;
      ab(TELA_ERR_RXP, 1'b1);
      rd(TELA_OFF_STAT, 32'h0);
      $display("test receive done");
      mode <= 8'h80;
      line.send(8'h07);
      rd(TELA_OFF_STAT, 32'h0);
      line.send(8'h03);
      rd(TELA_OFF_STAT, 32'h5);
      mode <= 8'h40;
      bufx(1'b1);
      bufx(1'b0);
      rd(TELA_OFF_STAT, 32'h25);
      apb(TELA_OFF_CTRL, 1'b1, 32'h1);
      bufx(1'b0);
      rd(TELA_OFF_STAT, 32'h2d);
      mode <= 8'h41;
      ab(TELA_ERR_NONE, 1'b0);
      chk("neg ack", 32'h1, {31'h0, qneg});
      rd(TELA_OFF_STAT, 32'h2d);
      mode <= 8'h43;
      ab(TELA_ERR_ELEC, 1'b1);
      rd(TELA_OFF_STAT, 32'h1);
      apb(TELA_OFF_CMD, 1'b1, 32'h1);
      $display("test transmit and buffer done");
      mode <= 8'h40;
      prt(7'h01, 7'h01);
      rd(TELA_OFF_STAT, 32'h0);
      prt(7'h01, 7'h00);
      rd(TELA_OFF_STAT, 32'h50);
      apb(TELA_OFF_CMD, 1'b1, 32'h2);
      rd(TELA_OFF_STAT, 32'h10);
      mode <= 8'h42;
      ab(TELA_ERR_PRT, 1'b1);
      prt(7'h01, 7'h03);
      rd(TELA_OFF_STAT, 32'h50);
      apb(TELA_OFF_CMD, 1'b1, 32'h2);
      ab(TELA_ERR_PRT, 1'b1);
      pulse(5);
      pulse(6);
      prt(7'h01, 7'h00);
      rd(TELA_OFF_STAT, 32'h20);
      mode <= 8'h80;
      prt(7'h01, 7'h00);
      rd(TELA_OFF_STAT, 32'h20);
      $display("test printer done");
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      rd(TELA_OFF_STAT, 32'h0);
      rd(TELA_OFF_CTRL, 32'h0);
      $display("test second reset done");
      wrap_up();
   end
endmodule // tela_tb_top
bind tela_top tela_assertions u_chk (.clk_i, .rst_n_i, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pready, .mode_i, .cycle_phase_two_i, .incorrect_case_i, .load_first_answerback_i,
   .err_o, .buffer_parity_fault_o, .error_sample_o, .parity_light_o, .ack_hold_o,
   .ack_qual_pos_o, .ack_qual_neg_o);
`default_nettype wire
